// ---- verilog/packed_int_simd_alu.sv ----
// packed integer simd execution unit with one registered result stage
`timescale 1ns/1ps
`default_nettype none

module packed_int_simd_alu
  import simd_alu_pkg::*;
#(
  parameter int OPW = OPW_MAX             // operand width in bits
)(
  input  wire logic      mclk_i,          // core clock, 250 MHz
  input  wire logic      rst_i,           // asynchronous reset, active high
  input  wire logic      req_valid_i,     // request strobe from decode
  input  wire simd_req_t req_i,           // request fields
  output var  simd_rsp_t rsp_o            // registered result
);

  // --------------------------------------------------------------------
  // elaboration checks
  // --------------------------------------------------------------------
  // lane loops below assume an operand of exactly 128 bits
  if (OPW != OPW_MAX)
  begin : g_bad_width
    $error("packed_int_simd_alu: OPW must be 128");
  end

  localparam int NB = OPW / 8;            // bytes
  localparam int NW = OPW / 16;           // words
  localparam int ND = OPW / 32;           // dwords

  // --------------------------------------------------------------------
  // saturation helper
  // --------------------------------------------------------------------
  // clamp a 17-bit signed value into signed 16-bit range
  function automatic logic [15:0] sat16(input logic [16:0] v);
    logic [15:0] r;
    r = v[15:0];
    if (v[16] && !v[15])
    begin
      r = 16'h8000;                       // below minimum
    end
    else if (!v[16] && v[15])
    begin
      r = 16'h7FFF;                       // above maximum
    end
    return r;
  endfunction

  // --------------------------------------------------------------------
  // operand view
  // --------------------------------------------------------------------
  // in the 64-bit form only the low half counts; upper half is masked off
  logic [OPW-1:0] d_v;                    // destination operand as used
  logic [OPW-1:0] s_v;                    // source operand as used
  logic [2*OPW-1:0] cat_v;                // horizontal view: src above dst
  logic [OPW-1:0] hw_add;                 // horizontal word add result
  logic [OPW-1:0] hw_adds;                // saturated horizontal word add
  logic [OPW-1:0] hw_sub;                 // horizontal word subtract
  logic [OPW-1:0] hw_subs;                // saturated horizontal word subtract
  logic [OPW-1:0] hd_add;                 // horizontal dword add
  logic [OPW-1:0] hd_sub;                 // horizontal dword subtract
  logic [OPW-1:0] abs_b;                  // absolute bytes
  logic [OPW-1:0] abs_w;                  // absolute words
  logic [OPW-1:0] abs_d;                  // absolute dwords
  logic [OPW-1:0] maddub;                 // byte multiply pair add
  logic [OPW-1:0] mulhrs;                 // rounded high multiply
  logic [OPW-1:0] shuf;                   // byte shuffle
  logic [OPW-1:0] sgn_b;                  // conditional negate bytes
  logic [OPW-1:0] sgn_w;                  // conditional negate words
  logic [OPW-1:0] sgn_d;                  // conditional negate dwords
  logic [OPW-1:0] algn;                   // align right

  assign d_v = req_i.wide ? req_i.dst : {{(OPW/2){1'b0}}, req_i.dst[OPW/2-1:0]};
  assign s_v = req_i.wide ? req_i.src : {{(OPW/2){1'b0}}, req_i.src[OPW/2-1:0]};

  // horizontal ops take pairs from dst first then src; pack the active
  // width contiguously so the narrow form reuses the same lanes
  assign cat_v = req_i.wide ? {s_v, d_v}
                            : {{OPW{1'b0}}, s_v[OPW/2-1:0], d_v[OPW/2-1:0]};

  // --------------------------------------------------------------------
  // word lanes: horizontal word ops, abs, sign, multiplies
  // --------------------------------------------------------------------
  for (genvar i = 0; i < NW; i++)
  begin : g_word
    logic [15:0] lo;                      // lower element of pair i
    logic [15:0] hi;                      // upper element of pair i
    logic [16:0] sum;                     // widened sum
    logic [16:0] dif;                     // widened difference
    logic [15:0] dw;                      // dst word i
    logic [15:0] sw;                      // src word i
    logic signed [31:0] prod;             // signed product
    logic [17:0] t18;                     // top 18 bits plus rounding
    logic signed [15:0] pa;               // first byte product
    logic signed [15:0] pb;               // second byte product
    logic [16:0] psum;                    // product pair sum
    assign lo   = cat_v[32*i +: 16];
    assign hi   = cat_v[32*i+16 +: 16];
    assign sum  = {lo[15], lo} + {hi[15], hi};
    assign dif  = {lo[15], lo} - {hi[15], hi};
    assign hw_add[16*i +: 16]  = sum[15:0];
    assign hw_adds[16*i +: 16] = sat16(sum);
    assign hw_sub[16*i +: 16]  = dif[15:0];
    assign hw_subs[16*i +: 16] = sat16(dif);
    assign dw = d_v[16*i +: 16];
    assign sw = s_v[16*i +: 16];
    assign abs_w[16*i +: 16] = dw[15] ? 16'(-dw) : dw;
    assign sgn_w[16*i +: 16] = sw[15] ? 16'(-dw) : ((sw == 16'h0000) ? 16'h0000 : dw);
    assign prod = 32'($signed(dw)) * 32'($signed(sw));
    assign t18  = 18'(prod[31:14] + 18'h0_0001);
    assign mulhrs[16*i +: 16] = t18[16:1];
    // unsigned dst byte times signed src byte
    assign pa = 16'($signed({1'b0, dw[7:0]}) * $signed(sw[7:0]));
    assign pb = 16'($signed({1'b0, dw[15:8]}) * $signed(sw[15:8]));
    assign psum = {pa[15], pa} + {pb[15], pb};
    assign maddub[16*i +: 16] = sat16(psum);
  end

  // --------------------------------------------------------------------
  // dword lanes
  // --------------------------------------------------------------------
  for (genvar i = 0; i < ND; i++)
  begin : g_dword
    logic [31:0] lo;                      // lower element of pair i
    logic [31:0] hi;                      // upper element of pair i
    logic [31:0] dd;                      // dst dword i
    logic [31:0] sd;                      // src dword i
    assign lo = cat_v[64*i +: 32];
    assign hi = cat_v[64*i+32 +: 32];
    assign hd_add[32*i +: 32] = lo + hi;
    assign hd_sub[32*i +: 32] = lo - hi;
    assign dd = d_v[32*i +: 32];
    assign sd = s_v[32*i +: 32];
    assign abs_d[32*i +: 32] = dd[31] ? 32'(-dd) : dd;
    assign sgn_d[32*i +: 32] = sd[31] ? 32'(-dd) : ((sd == 32'h0000_0000) ? 32'h0000_0000 : dd);
  end

  // --------------------------------------------------------------------
  // byte lanes: abs, sign, shuffle
  // --------------------------------------------------------------------
  for (genvar i = 0; i < NB; i++)
  begin : g_byte
    logic [7:0] db;                       // dst byte i
    logic [7:0] sb;                       // src byte i (shuffle control)
    logic [3:0] idx;                      // shuffle index
    assign db = d_v[8*i +: 8];
    assign sb = s_v[8*i +: 8];
    assign abs_b[8*i +: 8] = db[7] ? 8'(-db) : db;
    assign sgn_b[8*i +: 8] = sb[7] ? 8'(-db) : ((sb == 8'h00) ? 8'h00 : db);
    // narrow form indexes only the eight low bytes
    assign idx = req_i.wide ? sb[3:0] : {1'b0, sb[2:0]};
    // control bit 7 zeroes the result byte; the low bits only pick the dst byte
    assign shuf[8*i +: 8] = sb[7] ? 8'h00 : d_v[8*idx +: 8];
  end

  // --------------------------------------------------------------------
  // align right
  // --------------------------------------------------------------------
  // offsets past the double width give zero, as the shift fills with zeros
  always_comb
  begin
    logic [2*OPW-1:0] pair;               // dst above src
    logic [2*OPW-1:0] shifted;            // after byte shift
    pair    = req_i.wide ? {d_v, s_v}
                         : {{OPW{1'b0}}, d_v[OPW/2-1:0], s_v[OPW/2-1:0]};
    shifted = pair >> {req_i.imm, 3'b000};
    algn    = req_i.wide ? shifted[OPW-1:0]
                         : {{(OPW/2){1'b0}}, shifted[OPW/2-1:0]};
  end

  // --------------------------------------------------------------------
  // result select and register
  // --------------------------------------------------------------------
  simd_rsp_t rsp_r;                       // registered answer
  simd_rsp_t rsp_nxt;                     // next answer

  // selector, width and imm all sampled with the operands in one cycle
  always_comb
  begin
    logic [OPW-1:0] res;                  // selected result
    res = '0;
    unique case (req_i.op)
      OP_HORIZ_ADD_WORD:        res = hw_add;
      OP_HORIZ_ADD_WORD_SAT:    res = hw_adds;
      OP_HORIZ_ADD_DWORD:       res = hd_add;
      OP_HORIZ_SUB_WORD:        res = hw_sub;
      OP_HORIZ_SUB_WORD_SAT:    res = hw_subs;
      OP_HORIZ_SUB_DWORD:       res = hd_sub;
      OP_ABS_BYTE:              res = abs_b;
      OP_ABS_WORD:              res = abs_w;
      OP_ABS_DWORD:             res = abs_d;
      OP_BYTE_MUL_PAIR_ADD_SAT: res = maddub;
      OP_MUL_HIGH_ROUND_SCALE:  res = mulhrs;
      OP_BYTE_SHUFFLE:          res = shuf;
      OP_COND_NEGATE_BYTE:      res = sgn_b;
      OP_COND_NEGATE_WORD:      res = sgn_w;
      OP_COND_NEGATE_DWORD:     res = sgn_d;
      OP_CONCAT_ALIGN_RIGHT:    res = algn;
    endcase
    // narrow form: upper half of result reads zero
    if (!req_i.wide)
    begin
      res[OPW-1:OPW/2] = '0;
    end
    rsp_nxt.valid = req_valid_i;
    // hold data when idle so the result stays readable
    rsp_nxt.data  = req_valid_i ? res : rsp_r.data;
  end

  // register stage
  always_ff @(posedge mclk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      rsp_r <= '0;
    end
    else
    begin
      rsp_r <= rsp_nxt;
    end
  end

  assign rsp_o = rsp_r;

  // --------------------------------------------------------------------
  // assertions
  // --------------------------------------------------------------------
  valid_latency_a: assert property (@(posedge mclk_i) disable iff (rst_i)
    req_valid_i |=> rsp_o.valid)
    else $error("result valid did not follow request");

  hadd_word_a: assert property (@(posedge mclk_i) disable iff (rst_i)
    (req_valid_i && req_i.op == OP_HORIZ_ADD_WORD && req_i.wide)
    |=> rsp_o.data[15:0] == 16'($past(req_i.dst[15:0]) + $past(req_i.dst[31:16])))
    else $error("horizontal word add lane 0 wrong");

  hsub_dword_a: assert property (@(posedge mclk_i) disable iff (rst_i)
    (req_valid_i && req_i.op == OP_HORIZ_SUB_DWORD && req_i.wide)
    |=> rsp_o.data[127:96] == 32'($past(req_i.src[95:64]) - $past(req_i.src[127:96])))
    else $error("horizontal dword subtract top lane wrong");

  hadd_sat_a: assert property (@(posedge mclk_i) disable iff (rst_i)
    (req_valid_i && req_i.op == OP_HORIZ_ADD_WORD_SAT
     && req_i.dst[15:0] == 16'h7FFF && req_i.dst[31:16] == 16'h0001)
    |=> rsp_o.data[15:0] == 16'h7FFF)
    else $error("saturating add did not clamp");

  shuf_zero_a: assert property (@(posedge mclk_i) disable iff (rst_i)
    (req_valid_i && req_i.op == OP_BYTE_SHUFFLE && req_i.src[7])
    |=> rsp_o.data[7:0] == 8'h00)
    else $error("shuffle byte with bit 7 set not zero");

  mulhrs_a: assert property (@(posedge mclk_i) disable iff (rst_i)
    (req_valid_i && req_i.op == OP_MUL_HIGH_ROUND_SCALE
     && req_i.dst[15:0] == 16'h4000 && req_i.src[15:0] == 16'h4000)
    |=> rsp_o.data[15:0] == 16'h2000)
    else $error("rounded high multiply lane 0 wrong");

  sign_zero_a: assert property (@(posedge mclk_i) disable iff (rst_i)
    (req_valid_i && req_i.op == OP_COND_NEGATE_BYTE && req_i.src[7:0] == 8'h00)
    |=> rsp_o.data[7:0] == 8'h00)
    else $error("zero sign source did not zero element");

  align_zero_a: assert property (@(posedge mclk_i) disable iff (rst_i)
    (req_valid_i && req_i.op == OP_CONCAT_ALIGN_RIGHT && req_i.wide && req_i.imm == 8'h00)
    |=> rsp_o.data == $past(req_i.src))
    else $error("align right by zero must return source");

  narrow_upper_a: assert property (@(posedge mclk_i) disable iff (rst_i)
    (req_valid_i && !req_i.wide) |=> rsp_o.data[127:64] == 64'h0000_0000_0000_0000)
    else $error("narrow form upper half not zero");

  // an idle cycle must not disturb the result that decode may still read
  data_hold_a: assert property (@(posedge mclk_i) disable iff (rst_i)
    !req_valid_i |=> rsp_o.data == $past(rsp_o.data))
    else $error("result data changed while idle");

  shuf_pick_a: assert property (@(posedge mclk_i) disable iff (rst_i)
    (req_valid_i && req_i.op == OP_BYTE_SHUFFLE && req_i.wide && !req_i.src[7])
    |=> rsp_o.data[7:0] == 8'($past(req_i.dst >> {req_i.src[3:0], 3'b000})))
    else $error("shuffle picked the wrong byte");

  neg_word_a: assert property (@(posedge mclk_i) disable iff (rst_i)
    (req_valid_i && req_i.op == OP_COND_NEGATE_WORD && req_i.src[15])
    |=> rsp_o.data[15:0] == 16'(-$past(req_i.dst[15:0])))
    else $error("word with negative sign source not negated");

endmodule

`default_nettype wire

// ---- include/simd_alu_pkg.sv ----
// package: opcodes, widths and carrier structs for the packed integer simd unit
package simd_alu_pkg;

  localparam int OPW_MAX   = 128;         // widest operand in bits
  localparam int OPW_NARROW = 64;         // narrow operand form in bits
  localparam int LAT_CYCLES = 1;          // cycles from request to result

  // operation selector
  typedef enum logic [3:0] {
    OP_HORIZ_ADD_WORD        = 4'h0,
    OP_HORIZ_ADD_WORD_SAT    = 4'h1,
    OP_HORIZ_ADD_DWORD       = 4'h2,
    OP_HORIZ_SUB_WORD        = 4'h3,
    OP_HORIZ_SUB_WORD_SAT    = 4'h4,
    OP_HORIZ_SUB_DWORD       = 4'h5,
    OP_ABS_BYTE              = 4'h6,
    OP_ABS_WORD              = 4'h7,
    OP_ABS_DWORD             = 4'h8,
    OP_BYTE_MUL_PAIR_ADD_SAT = 4'h9,
    OP_MUL_HIGH_ROUND_SCALE  = 4'hA,
    OP_BYTE_SHUFFLE          = 4'hB,
    OP_COND_NEGATE_BYTE      = 4'hC,
    OP_COND_NEGATE_WORD      = 4'hD,
    OP_COND_NEGATE_DWORD     = 4'hE,
    OP_CONCAT_ALIGN_RIGHT    = 4'hF
  } simd_op_t;

  // request from decode: both operands, selector, width and immediate
  typedef struct packed {
    simd_op_t             op;       // operation
    logic                 wide;     // 1: 128-bit form, 0: 64-bit form
    logic [7:0]           imm;      // byte offset for align-right
    logic [OPW_MAX-1:0]   dst;      // destination operand (first)
    logic [OPW_MAX-1:0]   src;      // source operand (second)
  } simd_req_t;

  // answer to the register file
  typedef struct packed {
    logic                 valid;    // result present this cycle
    logic [OPW_MAX-1:0]   data;     // destination result
  } simd_rsp_t;

endpackage

// ---- testbench/simd_decode_model.sv ----
// decode-side partner model that presents requests to the simd unit
`timescale 1ns/1ps
`default_nettype none

module simd_decode_model
  import simd_alu_pkg::*;
(
  input  wire logic      mclk_i,       // core clock
  input  wire logic      rst_i,        // reset, active high
  output var  logic      req_valid_o,  // request strobe
  output var  simd_req_t req_o         // request fields
);
  // ----------------------------------------------------------------
  // request driving
  // ----------------------------------------------------------------
  initial
  begin
    req_valid_o = 1'b0;
    req_o       = '0;
  end

  // all fields change together with the strobe, one edge per request
  task automatic issue(input simd_req_t r);
    @(posedge mclk_i);
    req_valid_o <= 1'b1;
    req_o       <= r;
  endtask

  // idle cycle: fields no longer hold the old request, so a design that
  // samples without the strobe shows up as a data mismatch
  task automatic idle();
    @(posedge mclk_i);
    req_valid_o <= 1'b0;
    req_o       <= simd_req_t'(~req_o);
  endtask
endmodule
`default_nettype wire

// ---- testbench/packed_int_simd_alu_tb.sv ----
// self-checking bench for the packed integer simd unit
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, e) \
  begin \
    checks_done++; \
    if ((a) !== (e)) \
    begin \
      fails++; \
      $display("BAD t=%0t got=%h exp=%h", $time, (a), (e)); \
    end \
  end

module packed_int_simd_alu_tb
  import simd_alu_pkg::*;
;
  logic        mclk_i = 1'b0;  // core clock
  logic        rst_i  = 1'b1;  // reset
  logic        req_valid;      // strobe from model
  simd_req_t   req;            // request from model
  simd_rsp_t   rsp;            // unit answer
  logic        taken;          // request taken last edge
  logic [127:0] exp_d = '0;    // expected result
  simd_op_t    last_op = OP_HORIZ_ADD_WORD;  // op of that result
  int          fails = 0;
  int          checks_done = 0;
  int          cycles = 0;
  int          seed = 32'h9a01ed8b;
  simd_req_t   r;
  logic [7:0]  imm_tab [6] = '{8'h00, 8'h08, 8'h0f, 8'h10, 8'h1f, 8'h20};
  logic [127:0] pat [3] = '{128'h8000_8000_8000_8000_8000_8000_8000_8000,
                           128'h7fff_7fff_7fff_7fff_7fff_7fff_7fff_7fff,
                           128'h8001_7f80_00ff_ff00_ff80_0000_7fff_0180};

  initial
  begin
    forever #2 mclk_i = ~mclk_i;
  end

  simd_decode_model u_simd_decode_model (.mclk_i(mclk_i), .rst_i(rst_i),
    .req_valid_o(req_valid), .req_o(req));
  packed_int_simd_alu u_packed_int_simd_alu (.mclk_i(mclk_i), .rst_i(rst_i),
    .req_valid_i(req_valid), .req_i(req), .rsp_o(rsp));

  // ----------------------------------------------------------------
  // reference arithmetic
  // ----------------------------------------------------------------
  // sign-extended element i of width w
  function automatic longint el(logic [127:0] v, int w, int i);
    longint x;
    x = longint'(v >> (i * w));
    return (x << (64 - w)) >>> (64 - w);
  endfunction

  function automatic logic [127:0] put(longint x, int w, int i);
    return (128'(x) & ((128'h1 << w) - 1)) << (i * w);
  endfunction

  function automatic longint sat16(longint x);
    return x > 32767 ? 32767 : (x < -32768 ? -32768 : x);
  endfunction

  function automatic logic [127:0] expect_res(simd_req_t q);
    int n, w, m, j;
    longint a, b, x;
    logic [127:0] d, s, v, y;
    logic [255:0] c;
    n = q.wide ? 128 : 64;
    d = q.wide ? q.dst : {64'h0, q.dst[63:0]};
    s = q.wide ? q.src : {64'h0, q.src[63:0]};
    y = '0;
    w = (q.op == OP_HORIZ_ADD_DWORD || q.op == OP_HORIZ_SUB_DWORD) ? 32 : 16;
    if (q.op inside {[OP_ABS_BYTE:OP_ABS_DWORD]}) w = 8 << (q.op - OP_ABS_BYTE);
    if (q.op inside {[OP_COND_NEGATE_BYTE:OP_COND_NEGATE_DWORD]})
      w = 8 << (q.op - OP_COND_NEGATE_BYTE);
    if (q.op == OP_BYTE_SHUFFLE) w = 8;
    m = n / w;
    for (int i = 0; i < m; i++)
    begin
      j = 2 * (i % (m / 2));
      v = (i < m / 2) ? d : s;
      a = el(d, w, i);
      b = el(s, w, i);
      case (q.op)
        OP_HORIZ_ADD_WORD, OP_HORIZ_ADD_WORD_SAT, OP_HORIZ_ADD_DWORD:
          x = el(v, w, j) + el(v, w, j + 1);
        OP_HORIZ_SUB_WORD, OP_HORIZ_SUB_WORD_SAT, OP_HORIZ_SUB_DWORD:
          x = el(v, w, j) - el(v, w, j + 1);
        OP_BYTE_MUL_PAIR_ADD_SAT:
          x = sat16((el(d, 8, 2 * i) & 255) * el(s, 8, 2 * i)
                    + (el(d, 8, 2 * i + 1) & 255) * el(s, 8, 2 * i + 1));
        OP_MUL_HIGH_ROUND_SCALE: x = (((a * b) >>> 14) + 1) >>> 1;
        OP_BYTE_SHUFFLE: x = b < 0 ? 0 : el(d, 8, int'(b & (q.wide ? 15 : 7)));
        OP_COND_NEGATE_BYTE, OP_COND_NEGATE_WORD, OP_COND_NEGATE_DWORD:
          x = b < 0 ? -a : (b == 0 ? 0 : a);
        default: x = a < 0 ? -a : a;
      endcase
      if (q.op == OP_HORIZ_ADD_WORD_SAT || q.op == OP_HORIZ_SUB_WORD_SAT) x = sat16(x);
      y |= put(x, w, i);
    end
    if (q.op == OP_CONCAT_ALIGN_RIGHT)
    begin
      c = q.wide ? {d, s} : {128'h0, d[63:0], s[63:0]};
      c = c >> (int'(q.imm) * 8);
      y = q.wide ? c[127:0] : {64'h0, c[63:0]};
    end
    return y;
  endfunction

  // ----------------------------------------------------------------
  // scoreboard: expectation follows each taken request by one edge
  // ----------------------------------------------------------------
  always @(posedge mclk_i)
  begin
    taken <= req_valid && !rst_i;
    if (rst_i) exp_d <= '0;
    else if (req_valid)
    begin
      exp_d   <= expect_res(req);
      last_op <= req.op;
    end
  end

  // checked mid-cycle, where the registered answer has settled
  always @(negedge mclk_i)
  begin
    if (rst_i) `CHK(rsp, simd_rsp_t'(0))
    else
    begin
      `CHK(rsp.valid, taken)
      case (last_op)
        OP_HORIZ_ADD_WORD, OP_HORIZ_ADD_WORD_SAT, OP_HORIZ_ADD_DWORD:
          `CHK(rsp.data, exp_d)
        OP_HORIZ_SUB_WORD, OP_HORIZ_SUB_WORD_SAT, OP_HORIZ_SUB_DWORD:
          `CHK(rsp.data, exp_d)
        OP_ABS_BYTE, OP_ABS_WORD, OP_ABS_DWORD:
          `CHK(rsp.data, exp_d)
        OP_BYTE_MUL_PAIR_ADD_SAT: `CHK(rsp.data, exp_d)
        OP_MUL_HIGH_ROUND_SCALE: `CHK(rsp.data, exp_d)
        OP_BYTE_SHUFFLE: `CHK(rsp.data, exp_d)
        OP_CONCAT_ALIGN_RIGHT: `CHK(rsp.data, exp_d)
        default: `CHK(rsp.data, exp_d)
      endcase
    end
  end

  // ----------------------------------------------------------------
  // closing and hang guard
  // ----------------------------------------------------------------
  task automatic test_done();
    if (fails == 0 && checks_done > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask

  always @(posedge mclk_i)
  begin
    cycles++;
    if (cycles == 20000)
    begin
      fails++;
      test_done();
    end
  end

  // ----------------------------------------------------------------
  // stimulus: saturation and offset corners, then random traffic
  // ----------------------------------------------------------------
  initial
  begin
    repeat (16) @(posedge mclk_i);
    rst_i <= 1'b0;
    // every op, both forms, extreme patterns back to back
    for (int o = 0; o < 16; o++)
      for (int p = 0; p < 12; p++)
      begin
        r.op   = simd_op_t'(o);
        r.wide = (p >= 6);
        r.imm  = imm_tab[p % 6];
        r.dst  = pat[p % 3];
        r.src  = pat[(p + 1) % 3];
        u_simd_decode_model.issue(r);
      end
    // corners: saturating pair, half-scale multiply, align by zero bytes
    r = '{OP_HORIZ_ADD_WORD_SAT, 1'b1, 8'h00, {96'h0, 32'h0001_7fff}, pat[1]};
    u_simd_decode_model.issue(r);
    r = '{OP_MUL_HIGH_ROUND_SCALE, 1'b1, 8'h00, {8{16'h4000}}, {8{16'h4000}}};
    u_simd_decode_model.issue(r);
    r.op  = OP_CONCAT_ALIGN_RIGHT;
    r.src = pat[2];
    u_simd_decode_model.issue(r);
    // random ops and operands, with idle gaps now and then
    for (int k = 0; k < 3000; k++)
    begin
      r.op   = simd_op_t'(4'($random(seed)));
      r.wide = 1'($random(seed));
      r.imm  = 8'($random(seed));
      r.dst  = {$random(seed), $random(seed), $random(seed), $random(seed)};
      r.src  = {$random(seed), $random(seed), $random(seed), $random(seed)};
      if ($random(seed) % 4 == 0) u_simd_decode_model.idle();
      u_simd_decode_model.issue(r);
    end
    u_simd_decode_model.idle();
    repeat (3) @(posedge mclk_i);
    test_done();
  end
endmodule
`default_nettype wire
